// ### verilog/pdma_regs.svh
// Behaviour
// - Full duplex: separate receive and transmit channels.
// - Half duplex: one shared bidirectional channel.
// - Pointer advances by 1, 2 or 4.
// - Pointer rewritten mid-transfer: continue from it.
// - Current and next 16-bit counters; current decrements.
// - Both counters zero: stop, raise completion flag.
// - Next nonzero: reload current, clear next, resume.
// - Receive end flag when receive count hits zero.
// - Receive full flag when both receive counts zero.
// - Transmit end flag when transmit count hits zero.
// - Transmit empty flag when both transmit counts zero.
// - Nonzero count write clears that direction's flags.
// - Peripheral triggers start transfers per direction.
// - Receive ready: read holding register, store memory.
// - Transmit ready: fetch memory, fill holding register.
// - Flags go only to the peripheral status.
// - Half duplex flags belong to one channel.
// - Zero count stops; nonzero starts when enabled.
// - Half duplex pointers and counters share storage.
// - Ten registers from offset 0x100, word steps.
// - Enable bit works unless matching disable set; in half duplex any disable blocks it.
// - Status bit 0 receive, bit 8 transmit enable.
`ifndef PDMA_REGS_SVH
`define PDMA_REGS_SVH

// Register offsets inside the peripheral's space.
`define PDMA_OFF_RX_CUR_PTR 12'h100
`define PDMA_OFF_RX_CUR_CNT 12'h104
`define PDMA_OFF_TX_CUR_PTR 12'h108
`define PDMA_OFF_TX_CUR_CNT 12'h10c
`define PDMA_OFF_RX_NXT_PTR 12'h110
`define PDMA_OFF_RX_NXT_CNT 12'h114
`define PDMA_OFF_TX_NXT_PTR 12'h118
`define PDMA_OFF_TX_NXT_CNT 12'h11c
`define PDMA_OFF_CTRL       12'h120
`define PDMA_OFF_STATUS     12'h124

// Field positions of the control and status words.
`define PDMA_BIT_RX_EN  0
`define PDMA_BIT_RX_DIS 1
`define PDMA_BIT_TX_EN  8
`define PDMA_BIT_TX_DIS 9

// Widths and reset values.
`define PDMA_PTR_W   32
`define PDMA_CNT_W   16
`define PDMA_RST_PTR 32'h0
`define PDMA_RST_CNT 16'h0

`endif

// ### verilog/pdma_pkg.sv
`include "pdma_regs.svh"
package pdma_pkg;
    // Item width requested by the peripheral.
    typedef enum logic [1:0] {PDMA_SZ_BYTE, PDMA_SZ_HALF, PDMA_SZ_WORD} pdma_size_t;

    // Sequencer states of the transfer engine.
    typedef enum logic [1:0] {PDMA_IDLE, PDMA_RX_STORE, PDMA_TX_FETCH} pdma_state_t;

    // Storage of one pointer and counter set pair.
    typedef struct packed {
        logic [`PDMA_PTR_W-1:0] cur_ptr;
        logic [`PDMA_CNT_W-1:0] cur_cnt;
        logic [`PDMA_PTR_W-1:0] nxt_ptr;
        logic [`PDMA_CNT_W-1:0] nxt_cnt;
    } pdma_chan_st_t;

    // Whole state of the top-level engine.
    typedef struct packed {
        pdma_state_t      st;
        pdma_size_t       size;
        logic             rx_req_en;
        logic             tx_req_en;
        logic             rx_end;
        logic             rx_full;
        logic             tx_end;
        logic             tx_empty;
        logic             rx_hold_read;
        logic             tx_hold_write;
        logic [31:0]      rdata;
        logic [31:0]      buf_data;
        logic [31:0]      tx_data;
    } pdma_top_st_t;

    // Byte step of the memory pointer for one item.
    function automatic logic [`PDMA_PTR_W-1:0] pdma_step(input pdma_size_t sz);
        unique case (sz)
            PDMA_SZ_BYTE: pdma_step = 32'h1;
            PDMA_SZ_HALF: pdma_step = 32'h2;
            PDMA_SZ_WORD: pdma_step = 32'h4;
            default:      pdma_step = 32'h4;
        endcase
    endfunction : pdma_step
endpackage : pdma_pkg

// ### verilog/pdma_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdma_regs.svh"
// One pointer and counter pair set with software writes and automatic reload.
module pdma_chan (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        wr_cur_ptr,
    input  wire logic        wr_cur_cnt,
    input  wire logic        wr_nxt_ptr,
    input  wire logic        wr_nxt_cnt,
    input  wire logic [31:0] wdata,
    input  wire logic        step,
    input  wire logic [31:0] step_bytes,
    output logic      [31:0] cur_ptr,
    output logic      [15:0] cur_cnt,
    output logic      [31:0] nxt_ptr,
    output logic      [15:0] nxt_cnt,
    output logic             last,
    output logic             drained
);
    import pdma_pkg::*;

    pdma_chan_st_t q;   // Registered pair set.
    pdma_chan_st_t d;   // Next value of the pair set.
    logic          any_wr; // Any software write this cycle.

    assign any_wr  = wr_cur_ptr | wr_cur_cnt | wr_nxt_ptr | wr_nxt_cnt;
    assign cur_ptr = q.cur_ptr;
    assign cur_cnt = q.cur_cnt;
    assign nxt_ptr = q.nxt_ptr;
    assign nxt_cnt = q.nxt_cnt;
    // The item that empties the current counter, and whether nothing follows.
    assign last    = step && (q.cur_cnt == 16'h1);
    assign drained = last && (q.nxt_cnt == 16'h0);

    // Advance, then software writes, then reload of an empty current set.
    always_comb begin
        d = q;
        if (step) begin
            d.cur_ptr = q.cur_ptr + step_bytes;
            d.cur_cnt = q.cur_cnt - 16'h1;
        end
        // A write wins over the advance so the new address is used next.
        if (wr_cur_ptr) begin
            d.cur_ptr = wdata;
        end
        if (wr_cur_cnt) begin
            d.cur_cnt = wdata[15:0];
        end
        if (wr_nxt_ptr) begin
            d.nxt_ptr = wdata;
        end
        if (wr_nxt_cnt) begin
            d.nxt_cnt = wdata[15:0];
        end
        // An empty current set takes over a waiting next set.
        if ((d.cur_cnt == 16'h0) && (d.nxt_cnt != 16'h0)) begin
            d.cur_ptr = d.nxt_ptr;
            d.cur_cnt = d.nxt_cnt;
            d.nxt_ptr = `PDMA_RST_PTR;
            d.nxt_cnt = `PDMA_RST_CNT;
        end
    end

    // Register the pair set.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '{`PDMA_RST_PTR, `PDMA_RST_CNT, `PDMA_RST_PTR, `PDMA_RST_CNT};
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_chan_reload;
        (last && !drained && !any_wr) |=> (cur_cnt == $past(nxt_cnt)) && (nxt_cnt == 16'h0);
    endproperty
    a_chan_reload: assert property (p_chan_reload) else $error("reload failed");

    property p_chan_advance;
        (step && (cur_cnt > 16'h1) && !any_wr)
            |=> (cur_ptr == $past(cur_ptr) + $past(step_bytes)) && (cur_cnt == $past(cur_cnt) - 16'h1);
    endproperty
    a_chan_advance: assert property (p_chan_advance) else $error("advance wrong");

    property p_chan_newaddr;
        (wr_cur_ptr && !wr_cur_cnt && (cur_cnt > 16'h1)) |=> (cur_ptr == $past(wdata));
    endproperty
    a_chan_newaddr: assert property (p_chan_newaddr) else $error("new address lost");
endmodule : pdma_chan
`default_nettype wire

// ### verilog/pdma_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdma_regs.svh"
// Peripheral DMA channel pair: register file, request control and transfer engine.
module pdma_top (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                half_duplex,
    input  wire pdma_pkg::pdma_size_t xfer_size,
    input  wire logic         [11:0] reg_addr,
    input  wire logic         [31:0] reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic              [31:0] reg_rdata,
    input  wire logic                receive_trigger,
    input  wire logic                transmit_trigger,
    input  wire logic                rx_ready,
    input  wire logic         [31:0] receive_holding_reg,
    output logic                     rx_hold_read,
    input  wire logic                tx_ready,
    output logic              [31:0] transmit_holding_reg,
    output logic                     tx_hold_write,
    output logic                     mem_req,
    output logic                     mem_write,
    output logic              [31:0] mem_addr,
    output pdma_pkg::pdma_size_t     mem_size,
    output logic              [31:0] mem_wdata,
    input  wire logic                mem_gnt,
    input  wire logic         [31:0] mem_rdata,
    output logic                     rx_end_flag,
    output logic                     rx_buffer_full_flag,
    output logic                     tx_end_flag,
    output logic                     tx_buffer_empty_flag
);
    import pdma_pkg::*;

    pdma_top_st_t q;            // Registered engine state.
    pdma_top_st_t d;            // Next engine state.

    // Write strobes decoded per register.
    logic        w_rx_cp;       // Receive current pointer write.
    logic        w_rx_cc;       // Receive current count write.
    logic        w_tx_cp;       // Transmit current pointer write.
    logic        w_tx_cc;       // Transmit current count write.
    logic        w_rx_np;       // Receive next pointer write.
    logic        w_rx_nc;       // Receive next count write.
    logic        w_tx_np;       // Transmit next pointer write.
    logic        w_tx_nc;       // Transmit next count write.
    logic        w_ctrl;        // Control word write.
    logic        clr_rx;        // Nonzero receive count written.
    logic        clr_tx;        // Nonzero transmit count written.

    // Channel views.
    logic [31:0] a_cp, a_np, b_cp, b_np;    // Pointers of the two storages.
    logic [15:0] a_cc, a_nc, b_cc, b_nc;    // Counters of the two storages.
    logic        a_last, a_drained;         // Receive (or shared) storage events.
    logic        b_last, b_drained;         // Transmit storage events.
    logic [31:0] tx_cp, tx_np;              // Transmit view of pointers.
    logic [15:0] tx_cc, tx_nc;              // Transmit view of counters.
    logic        tx_last, tx_drained;       // Transmit view of events.
    logic        rx_step, tx_step;          // One item completed per direction.
    logic        rx_go, tx_go;              // Direction may start an item.
    logic [31:0] step_bytes;                // Pointer step of the item in flight.

    // True when the bus address matches a register offset.
    function automatic logic hit(input logic [11:0] off);
        hit = (reg_addr == off);
    endfunction : hit

    // Both registers of the same kind land in one storage in half duplex.
    assign w_rx_cp = reg_wr && (hit(`PDMA_OFF_RX_CUR_PTR) || (half_duplex && hit(`PDMA_OFF_TX_CUR_PTR)));
    assign w_rx_cc = reg_wr && (hit(`PDMA_OFF_RX_CUR_CNT) || (half_duplex && hit(`PDMA_OFF_TX_CUR_CNT)));
    assign w_rx_np = reg_wr && (hit(`PDMA_OFF_RX_NXT_PTR) || (half_duplex && hit(`PDMA_OFF_TX_NXT_PTR)));
    assign w_rx_nc = reg_wr && (hit(`PDMA_OFF_RX_NXT_CNT) || (half_duplex && hit(`PDMA_OFF_TX_NXT_CNT)));
    assign w_tx_cp = reg_wr && !half_duplex && hit(`PDMA_OFF_TX_CUR_PTR);
    assign w_tx_cc = reg_wr && !half_duplex && hit(`PDMA_OFF_TX_CUR_CNT);
    assign w_tx_np = reg_wr && !half_duplex && hit(`PDMA_OFF_TX_NXT_PTR);
    assign w_tx_nc = reg_wr && !half_duplex && hit(`PDMA_OFF_TX_NXT_CNT);
    assign w_ctrl  = reg_wr && hit(`PDMA_OFF_CTRL);

    // Flag clears follow the register named by the address, not the storage.
    assign clr_rx = reg_wr && (reg_wdata[15:0] != 16'h0)
                    && (hit(`PDMA_OFF_RX_CUR_CNT) || hit(`PDMA_OFF_RX_NXT_CNT));
    assign clr_tx = reg_wr && (reg_wdata[15:0] != 16'h0)
                    && (hit(`PDMA_OFF_TX_CUR_CNT) || hit(`PDMA_OFF_TX_NXT_CNT));

    // Item completion strobes: the memory access is granted.
    assign rx_step    = (q.st == PDMA_RX_STORE) && mem_gnt;
    assign tx_step    = (q.st == PDMA_TX_FETCH) && mem_gnt;
    assign step_bytes = pdma_step(q.size);

    // Receive storage, also the single storage of a half-duplex channel.
    pdma_chan u_chan_a (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .wr_cur_ptr (w_rx_cp),
        .wr_cur_cnt (w_rx_cc),
        .wr_nxt_ptr (w_rx_np),
        .wr_nxt_cnt (w_rx_nc),
        .wdata      (reg_wdata),
        .step       (rx_step || (half_duplex && tx_step)),
        .step_bytes (step_bytes),
        .cur_ptr    (a_cp),
        .cur_cnt    (a_cc),
        .nxt_ptr    (a_np),
        .nxt_cnt    (a_nc),
        .last       (a_last),
        .drained    (a_drained)
    );

    // Transmit storage, idle in half duplex.
    pdma_chan u_chan_b (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .wr_cur_ptr (w_tx_cp),
        .wr_cur_cnt (w_tx_cc),
        .wr_nxt_ptr (w_tx_np),
        .wr_nxt_cnt (w_tx_nc),
        .wdata      (reg_wdata),
        .step       (tx_step && !half_duplex),
        .step_bytes (step_bytes),
        .cur_ptr    (b_cp),
        .cur_cnt    (b_cc),
        .nxt_ptr    (b_np),
        .nxt_cnt    (b_nc),
        .last       (b_last),
        .drained    (b_drained)
    );

    // Transmit direction sees the shared storage in half duplex.
    assign tx_cp      = half_duplex ? a_cp : b_cp;
    assign tx_np      = half_duplex ? a_np : b_np;
    assign tx_cc      = half_duplex ? a_cc : b_cc;
    assign tx_nc      = half_duplex ? a_nc : b_nc;
    assign tx_last    = half_duplex ? a_last : b_last;
    assign tx_drained = half_duplex ? a_drained : b_drained;

    // A direction runs only when enabled, triggered, ready and counting.
    assign rx_go = q.rx_req_en && receive_trigger && rx_ready && (a_cc != 16'h0);
    assign tx_go = q.tx_req_en && transmit_trigger && tx_ready && (tx_cc != 16'h0);

    // Memory side: write buffered receive item, or fetch a transmit item.
    assign mem_req    = (q.st != PDMA_IDLE);
    assign mem_write  = (q.st == PDMA_RX_STORE);
    assign mem_addr   = (q.st == PDMA_TX_FETCH) ? tx_cp : a_cp;
    assign mem_size   = q.size;
    assign mem_wdata  = q.buf_data;

    // Outputs straight from the state register.
    assign reg_rdata            = q.rdata;
    assign rx_hold_read         = q.rx_hold_read;
    assign tx_hold_write        = q.tx_hold_write;
    assign transmit_holding_reg = q.tx_data;
    assign rx_end_flag          = q.rx_end;
    assign rx_buffer_full_flag  = q.rx_full;
    assign tx_end_flag          = q.tx_end;
    assign tx_buffer_empty_flag = q.tx_empty;

    // Next-state logic of the whole engine.
    always_comb begin
        d = q;
        d.rx_hold_read  = 1'b0;
        d.tx_hold_write = 1'b0;
        d.rdata         = 32'h0;

        // Register reads: data stand in the cycle after the strobe.
        if (reg_rd) begin
            unique case (reg_addr)
                `PDMA_OFF_RX_CUR_PTR: d.rdata = a_cp;
                `PDMA_OFF_RX_CUR_CNT: d.rdata = {16'h0, a_cc};
                `PDMA_OFF_TX_CUR_PTR: d.rdata = tx_cp;
                `PDMA_OFF_TX_CUR_CNT: d.rdata = {16'h0, tx_cc};
                `PDMA_OFF_RX_NXT_PTR: d.rdata = a_np;
                `PDMA_OFF_RX_NXT_CNT: d.rdata = {16'h0, a_nc};
                `PDMA_OFF_TX_NXT_PTR: d.rdata = tx_np;
                `PDMA_OFF_TX_NXT_CNT: d.rdata = {16'h0, tx_nc};
                `PDMA_OFF_STATUS: begin
                    // Enable state of both directions.
                    d.rdata[`PDMA_BIT_RX_EN] = q.rx_req_en;
                    d.rdata[`PDMA_BIT_TX_EN] = q.tx_req_en;
                end
                // Control word is write only; unmapped offsets read zero.
                default: d.rdata = 32'h0;
            endcase
        end

        // Control writes: an enable counts only without its own disable, in half duplex without either disable.
        if (w_ctrl) begin
            if (!half_duplex) begin
                if (reg_wdata[`PDMA_BIT_RX_DIS]) begin
                    d.rx_req_en = 1'b0;
                end else if (reg_wdata[`PDMA_BIT_RX_EN]) begin
                    d.rx_req_en = 1'b1;
                end
                if (reg_wdata[`PDMA_BIT_TX_DIS]) begin
                    d.tx_req_en = 1'b0;
                end else if (reg_wdata[`PDMA_BIT_TX_EN]) begin
                    d.tx_req_en = 1'b1;
                end
            end else if (reg_wdata[`PDMA_BIT_RX_DIS] || reg_wdata[`PDMA_BIT_TX_DIS]) begin
                // Either disable stops the shared channel in both directions.
                d.rx_req_en = 1'b0;
                d.tx_req_en = 1'b0;
            end else if (reg_wdata[`PDMA_BIT_RX_EN]) begin
                // Receive enable takes the shared channel from transmit.
                d.rx_req_en = 1'b1;
                d.tx_req_en = 1'b0;
            end else if (reg_wdata[`PDMA_BIT_TX_EN]) begin
                d.tx_req_en = 1'b1;
                d.rx_req_en = 1'b0;
            end
        end

        // Transfer sequencer; receive is served first when both are ready.
        unique case (q.st)
            PDMA_IDLE: begin
                if (rx_go) begin
                    // Take the item from the receive holding register into the buffer.
                    d.buf_data     = receive_holding_reg;
                    d.rx_hold_read = 1'b1;
                    d.size         = xfer_size;
                    d.st           = PDMA_RX_STORE;
                end else if (tx_go) begin
                    d.size = xfer_size;
                    d.st   = PDMA_TX_FETCH;
                end
            end
            PDMA_RX_STORE: begin
                // Hold the memory write request until the matrix grants it.
                if (mem_gnt) begin
                    d.st = PDMA_IDLE;
                end
            end
            PDMA_TX_FETCH: begin
                // Granted read data go to the transmit holding register.
                if (mem_gnt) begin
                    d.tx_data       = mem_rdata;
                    d.tx_hold_write = 1'b1;
                    d.st            = PDMA_IDLE;
                end
            end
            // The fourth state code is unused; fall back to idle.
            default: d.st = PDMA_IDLE;
        endcase

        // Sticky flags per direction; a setting event wins over a clear.
        d.rx_end   = (rx_step && a_last) || (q.rx_end && !clr_rx);
        d.rx_full  = (rx_step && a_drained) || (q.rx_full && !clr_rx);
        d.tx_end   = (tx_step && tx_last) || (q.tx_end && !clr_tx);
        d.tx_empty = (tx_step && tx_drained) || (q.tx_empty && !clr_tx);
    end

    // Register the engine state.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '{PDMA_IDLE, PDMA_SZ_BYTE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                   1'b0, 1'b0, 32'h0, 32'h0, 32'h0};
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Start of a receive item seen from the idle state.
    sequence s_rx_start;
        (q.st == PDMA_IDLE) && rx_go;
    endsequence

    // Buffered item presented as a memory write.
    sequence s_rx_store(logic [31:0] item);
        rx_hold_read && mem_req && mem_write && (mem_wdata == item);
    endsequence

    property p_rx_path;
        logic [31:0] item;
        (s_rx_start, item = receive_holding_reg) |=> s_rx_store(item);
    endproperty
    a_rx_path: assert property (p_rx_path) else $error("receive item not stored");

    property p_tx_path;
        tx_step |=> tx_hold_write && (transmit_holding_reg == $past(mem_rdata)) && !mem_req;
    endproperty
    a_tx_path: assert property (p_tx_path) else $error("transmit item not placed");

    property p_rx_end_set;
        (rx_step && a_last) |=> rx_end_flag ##0 (rx_buffer_full_flag == $past(a_drained));
    endproperty
    a_rx_end_set: assert property (p_rx_end_set) else $error("receive end flags wrong");

    property p_tx_empty_set;
        (tx_step && tx_drained) |=> tx_end_flag && tx_buffer_empty_flag;
    endproperty
    a_tx_empty_set: assert property (p_tx_empty_set) else $error("transmit empty not set");

    property p_rx_clear;
        (clr_rx && !rx_step) |=> !rx_end_flag && !rx_buffer_full_flag;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("receive flags not cleared");

    property p_ctrl_disable;
        (w_ctrl && reg_wdata[`PDMA_BIT_RX_DIS]) |=> !q.rx_req_en;
    endproperty
    a_ctrl_disable: assert property (p_ctrl_disable) else $error("disable ignored");

    property p_half_exclusive;
        half_duplex && $stable(half_duplex) |-> !(q.rx_req_en && q.tx_req_en);
    endproperty
    a_half_exclusive: assert property (p_half_exclusive) else $error("both enabled");

    property p_zero_stops;
        ((q.st == PDMA_IDLE) && (a_cc == 16'h0) && (tx_cc == 16'h0) && !reg_wr)
            |=> !mem_req[*2];
    endproperty
    a_zero_stops: assert property (p_zero_stops) else $error("zero count moved data");

    property p_status_read;
        (reg_rd && hit(`PDMA_OFF_STATUS))
            |=> (reg_rdata == {23'h0, $past(q.tx_req_en), 7'h0, $past(q.rx_req_en)});
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");
endmodule : pdma_top
`default_nettype wire

// ### tb/pdma_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Memory side of the bus matrix: grants at once, or every other cycle when slow.
module pdma_peer (
    input  wire logic        clk_sys,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_write,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_gnt,
    output logic      [31:0] mem_rdata,
    output logic      [31:0] wr_addr,
    output logic      [31:0] wr_data
);
    logic        wait_q = 1'b0;  // Phase of the slow grant.
    logic [31:0] junk_q = 32'h0; // Filler that changes every cycle.
    // Grant, and read data only in the granted cycle so stale data is never seen.
    assign mem_gnt   = mem_req && (!slow || wait_q);
    assign mem_rdata = (mem_gnt && !mem_write) ? (mem_addr ^ 32'h5a5a_0000) : junk_q;
    // Keep the last granted write for the bench.
    always_ff @(posedge clk_sys) begin
        wait_q <= mem_req && !wait_q;
        junk_q <= ~junk_q ^ 32'h1;
        if (mem_gnt && mem_write) begin
            wr_addr <= mem_addr;
            wr_data <= mem_wdata;
        end
    end
endmodule : pdma_peer
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Register and transfer checks of the channel pair.
module testbench;
    import pdma_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, half_duplex = 1'b0, slow = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rx_ready = 1'b0, tx_ready = 1'b0;
    logic receive_trigger = 1'b0, transmit_trigger = 1'b0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, receive_holding_reg = 32'h0;
    pdma_size_t xfer_size = PDMA_SZ_HALF, mem_size;
    logic [31:0] reg_rdata, transmit_holding_reg, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] wr_addr, wr_data;
    logic rx_hold_read, tx_hold_write, mem_req, mem_write, mem_gnt;
    logic rx_end_flag, rx_buffer_full_flag, tx_end_flag, tx_buffer_empty_flag;
    int fail_count = 0, checked = 0;
    pdma_top i_pdma_top (.clk_sys, .rst_n, .half_duplex, .xfer_size, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .receive_trigger, .transmit_trigger, .rx_ready,
        .receive_holding_reg, .rx_hold_read, .tx_ready, .transmit_holding_reg, .tx_hold_write,
        .mem_req, .mem_write, .mem_addr, .mem_size, .mem_wdata, .mem_gnt, .mem_rdata,
        .rx_end_flag, .rx_buffer_full_flag, .tx_end_flag, .tx_buffer_empty_flag);
    pdma_peer i_pdma_peer (.clk_sys, .slow, .mem_req, .mem_write, .mem_addr, .mem_wdata,
        .mem_gnt, .mem_rdata, .wr_addr, .wr_data);
    // Free-running 250 MHz clock.
    always #2 clk_sys = ~clk_sys;
    // Compare and count.
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One-cycle register write.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle register read, data checked in the following cycle.
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk("register", reg_rdata, e);
    endtask : rd
    // Offer one received item and check where it landed in memory.
    task automatic rx_item(input logic [31:0] d, input logic [31:0] a);
        int n;
        n = 0;
        @(posedge clk_sys);
        rx_ready <= 1'b1;
        receive_holding_reg <= d;
        while (!rx_hold_read && n < 40) begin @(posedge clk_sys); n++; end
        rx_ready <= 1'b0;
        while (mem_req && n < 80) begin @(posedge clk_sys); n++; end
        @(negedge clk_sys);
        chk("rx address", wr_addr, a);
        chk("rx data", wr_data, d);
    endtask : rx_item
    // Closing verdict.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // Watchdog against a hang.
    initial begin
        #20000;
        fail_count++;
        end_sim();
    end
    // Main sequence.
    initial begin
        int n;
        n = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rd(12'h100 + 12'(4 * i), 32'h0);
        wr(12'h100, 32'h1000);
        wr(12'h104, 32'h2);
        wr(12'h110, 32'h2000);
        wr(12'h114, 32'h1);
        wr(12'h120, 32'h1);
        rd(12'h124, 32'h1);
        receive_trigger <= 1'b1;
        rx_item(32'h11, 32'h1000);
        rx_item(32'h22, 32'h1002);
        rd(12'h100, 32'h2000);
        rd(12'h104, 32'h1);
        rd(12'h114, 32'h0);
        chk("rx end", 32'(rx_end_flag), 32'h1);
        chk("rx full", 32'(rx_buffer_full_flag), 32'h0);
        rx_item(32'h33, 32'h2000);
        chk("rx full", 32'(rx_buffer_full_flag), 32'h1);
        rx_ready <= 1'b1;
        rd(12'h100, 32'h2002);
        rx_ready <= 1'b0;
        wr(12'h114, 32'h5);
        @(negedge clk_sys);
        chk("rx end", 32'(rx_end_flag | rx_buffer_full_flag), 32'h0);
        wr(12'h120, 32'h3);
        rd(12'h124, 32'h0);
        slow <= 1'b1;
        xfer_size <= PDMA_SZ_WORD;
        wr(12'h108, 32'h3000);
        wr(12'h10c, 32'h1);
        wr(12'h120, 32'h100);
        rd(12'h124, 32'h100);
        transmit_trigger <= 1'b1;
        tx_ready <= 1'b1;
        while (!tx_hold_write && n < 40) begin @(posedge clk_sys); n++; end
        chk("tx holding", transmit_holding_reg, 32'h5a5a_3000);
        tx_ready <= 1'b0;
        @(negedge clk_sys);
        chk("tx flags", 32'({tx_end_flag, tx_buffer_empty_flag}), 32'h3);
        rd(12'h108, 32'h3004);
        wr(12'h11c, 32'h1);
        @(negedge clk_sys);
        chk("tx flags", 32'({tx_end_flag, tx_buffer_empty_flag}), 32'h0);
        // Half duplex: transmit offsets alias the shared storage, enables exclusive.
        half_duplex <= 1'b1;
        wr(12'h108, 32'h4000);
        rd(12'h100, 32'h4000);
        wr(12'h120, 32'h100);
        wr(12'h120, 32'h1);
        rd(12'h124, 32'h1);
        wr(12'h120, 32'h200);
        rd(12'h124, 32'h0);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
